// ---- rtl/arsc_pkg.sv ----
package arsc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] voltage_reference_control_addr = 8'hD1;
  localparam logic [7:0] voltage_reference_control_reset = 8'h18;
  localparam int analog_ground_select_bit = 5;
  localparam int reference_source_select_lsb = 3;
  localparam int thermal_sensor_enable_bit = 2;
  localparam logic [7:0] writable_mask = 8'h3C;
  // ==========================================================
  // channel code of the temperature sensor
  localparam logic [4:0] thermal_channel_code = 5'h1B;

  typedef enum logic [1:0]
  {
    arsc_ref_ext_pin = 2'h0,
    arsc_ref_supply = 2'h1,
    arsc_ref_digital_1v8 = 2'h2,
    arsc_ref_fast_1v65 = 2'h3
  } arsc_ref_t;

  typedef enum logic [1:0]
  {
    arsc_ph_idle,
    arsc_ph_track,
    arsc_ph_convert
  } arsc_phase_t;

  typedef struct packed
  {
    logic [1:0] reference_source;
    logic analog_ground_pin_sel;
    logic chip_ground_sel;
    logic fast_reference_on;
    logic thermal_sensor_on;
  } arsc_steer_t;
endpackage

// ---- rtl/arsc_phase_tracker.sv ----
module arsc_phase_tracker
(
  input wire logic clock,
  input wire logic rst,
  input wire logic converter_tracking,
  input wire logic converter_converting,
  output arsc_pkg::arsc_phase_t phase
);
  // ==========================================================
  // phase of the converter; conversion wins if both are raised
  arsc_pkg::arsc_phase_t next_phase;
  assign next_phase = converter_converting ? arsc_pkg::arsc_ph_convert :
                      converter_tracking ? arsc_pkg::arsc_ph_track : arsc_pkg::arsc_ph_idle;
  always_ff @(posedge clock)
  begin
    if (rst)
      phase <= arsc_pkg::arsc_ph_idle;
    else
      phase <= next_phase;
  end

  // ==========================================================
  // assertions
  property p_convert_wins;
    @(posedge clock) disable iff (rst) !rst && converter_converting |=> phase == arsc_pkg::arsc_ph_convert;
  endproperty
  a_convert_wins: assert property (p_convert_wins) else $error("conversion phase not taken");

  property p_track_taken;
    @(posedge clock) disable iff (rst)
      !rst && converter_tracking && !converter_converting |=> phase == arsc_pkg::arsc_ph_track;
  endproperty
  a_track_taken: assert property (p_track_taken) else $error("tracking phase not taken");
endmodule // arsc_phase_tracker

// ---- rtl/arsc_top.sv ----
module arsc_top
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  output logic [7:0] sfr_rdata,
  input wire logic [4:0] converter_positive_channel_select,
  input wire logic converter_tracking,
  input wire logic converter_converting,
  output arsc_pkg::arsc_steer_t steer
);
  // ==========================================================
  // register
  logic [7:0] voltage_reference_control;
  logic hit;
  logic [7:0] next_control;
  assign hit = sfr_addr == arsc_pkg::voltage_reference_control_addr;
  assign next_control = sfr_wdata & arsc_pkg::writable_mask;

  always_ff @(posedge clock)
  begin
    if (rst)
      voltage_reference_control <= arsc_pkg::voltage_reference_control_reset;
    else if (sfr_write && hit)
      voltage_reference_control <= next_control;
  end

  // read data registered; unmapped addresses read zero
  logic [7:0] next_rdata;
  assign next_rdata = (sfr_read && hit) ? (voltage_reference_control & arsc_pkg::writable_mask) : 8'h00;
  always_ff @(posedge clock)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= next_rdata;
  end

  // ==========================================================
  // phase
  arsc_pkg::arsc_phase_t phase;
  arsc_phase_tracker u_phase
  (
    .clock(clock),
    .rst(rst),
    .converter_tracking(converter_tracking),
    .converter_converting(converter_converting),
    .phase(phase)
  );

  // ==========================================================
  // steering
  logic [1:0] ref_sel;
  logic gnd_bit;
  logic thermal_meas;
  logic fast_ref;
  logic force_chip;
  logic busy;
  arsc_pkg::arsc_steer_t next_steer;
  assign ref_sel = voltage_reference_control[arsc_pkg::reference_source_select_lsb +: 2];
  assign gnd_bit = voltage_reference_control[arsc_pkg::analog_ground_select_bit];
  assign thermal_meas = converter_positive_channel_select == arsc_pkg::thermal_channel_code;
  assign fast_ref = ref_sel == arsc_pkg::arsc_ref_fast_1v65;
  assign busy = phase != arsc_pkg::arsc_ph_idle;
  // chip ground overrides: sensor sampling, and fast reference conversions
  assign force_chip = (thermal_meas && phase == arsc_pkg::arsc_ph_track) ||
                      (fast_ref && phase == arsc_pkg::arsc_ph_convert);
  assign next_steer.reference_source = ref_sel;
  assign next_steer.analog_ground_pin_sel = gnd_bit && !force_chip;
  assign next_steer.chip_ground_sel = !(gnd_bit && !force_chip);
  // powered only while a measurement runs; saves idle current
  assign next_steer.fast_reference_on = fast_ref && busy;
  assign next_steer.thermal_sensor_on = voltage_reference_control[arsc_pkg::thermal_sensor_enable_bit];

  always_ff @(posedge clock)
  begin
    if (rst)
      steer <= '0;
    else
      steer <= next_steer;
  end

  // ==========================================================
  // assertions
  property p_readzero;
    @(posedge clock) disable iff (rst) !rst |=> (sfr_rdata & ~arsc_pkg::writable_mask) == 8'h00;
  endproperty
  a_readzero: assert property (p_readzero) else $error("reserved bits not zero");

  property p_reset;
    @(posedge clock) rst |=> voltage_reference_control == arsc_pkg::voltage_reference_control_reset;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");

  property p_write;
    @(posedge clock) disable iff (rst)
      sfr_write && hit |=> voltage_reference_control == ($past(sfr_wdata) & arsc_pkg::writable_mask);
  endproperty
  a_write: assert property (p_write) else $error("write not taken");

  property p_ref;
    @(posedge clock) disable iff (rst) !rst |=> steer.reference_source == $past(ref_sel);
  endproperty
  a_ref: assert property (p_ref) else $error("reference route wrong");

  property p_fast;
    @(posedge clock) disable iff (rst) fast_ref && !busy |=> !steer.fast_reference_on;
  endproperty
  a_fast: assert property (p_fast) else $error("fast reference on while idle");

  sequence s_thermal_track;
    thermal_meas && phase == arsc_pkg::arsc_ph_track;
  endsequence
  property p_thermal_gnd;
    @(posedge clock) disable iff (rst) s_thermal_track |=> steer.chip_ground_sel;
  endproperty
  a_thermal_gnd: assert property (p_thermal_gnd) else $error("sensor sampling not on chip ground");

  property p_fast_gnd;
    @(posedge clock) disable iff (rst) fast_ref && phase == arsc_pkg::arsc_ph_convert |=> steer.chip_ground_sel;
  endproperty
  a_fast_gnd: assert property (p_fast_gnd) else $error("fast conversion not on chip ground");

  property p_analog_ground_pin;
    @(posedge clock) disable iff (rst) gnd_bit && !force_chip |=> steer.analog_ground_pin_sel;
  endproperty
  a_analog_ground_pin: assert property (p_analog_ground_pin) else $error("analog ground pin not used");

  property p_sensor;
    @(posedge clock) disable iff (rst)
      !rst |=> steer.thermal_sensor_on == $past(voltage_reference_control[arsc_pkg::thermal_sensor_enable_bit]);
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor enable wrong");

  // antecedents test the sampled reset: the release edge must not start an attempt
  sequence s_ctrl_write;
    !rst && sfr_write && hit;
  endsequence
  sequence s_ctrl_read;
    !rst && sfr_read && hit;
  endsequence
  sequence s_pin_track;
    !rst && gnd_bit && !thermal_meas && phase == arsc_pkg::arsc_ph_track;
  endsequence
  sequence s_pin_convert;
    !rst && gnd_bit && !fast_ref && phase == arsc_pkg::arsc_ph_convert;
  endsequence

  property p_analog_ground_pin_track;
    @(posedge clock) disable iff (rst) s_pin_track |=> steer.analog_ground_pin_sel;
  endproperty
  a_analog_ground_pin_track: assert property (p_analog_ground_pin_track) else $error("analog ground pin lost while tracking");

  property p_analog_ground_pin_convert;
    @(posedge clock) disable iff (rst) s_pin_convert |=> steer.analog_ground_pin_sel;
  endproperty
  a_analog_ground_pin_convert: assert property (p_analog_ground_pin_convert) else $error("analog ground pin lost while converting");

  property p_dev_gnd;
    @(posedge clock) disable iff (rst) !rst && !gnd_bit |=> steer.chip_ground_sel && !steer.analog_ground_pin_sel;
  endproperty
  a_dev_gnd: assert property (p_dev_gnd) else $error("device ground not used");

  property p_gnd_onehot;
    @(posedge clock) disable iff (rst) !rst |=> steer.analog_ground_pin_sel != steer.chip_ground_sel;
  endproperty
  a_gnd_onehot: assert property (p_gnd_onehot) else $error("ground selects not exclusive");

  property p_fast_on;
    @(posedge clock) disable iff (rst) !rst && fast_ref && busy |=> steer.fast_reference_on;
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("fast reference off during measurement");

  property p_fast_only;
    @(posedge clock) disable iff (rst) !rst && !fast_ref |=> !steer.fast_reference_on;
  endproperty
  a_fast_only: assert property (p_fast_only) else $error("fast reference on while not selected");

  property p_thermal_code;
    @(posedge clock) disable iff (rst)
      !rst && gnd_bit && converter_positive_channel_select == arsc_pkg::thermal_channel_code &&
      phase == arsc_pkg::arsc_ph_track |=> !steer.analog_ground_pin_sel;
  endproperty
  a_thermal_code: assert property (p_thermal_code) else $error("sensor channel not decoded");

  property p_other_code;
    @(posedge clock) disable iff (rst)
      !rst && gnd_bit && converter_positive_channel_select != arsc_pkg::thermal_channel_code &&
      phase == arsc_pkg::arsc_ph_track |=> steer.analog_ground_pin_sel;
  endproperty
  a_other_code: assert property (p_other_code) else $error("other channel taken for sensor");

  property p_reserved_write;
    @(posedge clock) disable iff (rst) s_ctrl_write |=> (voltage_reference_control & ~arsc_pkg::writable_mask) == 8'h00;
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved bits written");

  property p_unmapped_write;
    @(posedge clock) disable iff (rst) !rst && sfr_write && !hit |=> $stable(voltage_reference_control);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed register");

  property p_read_data;
    @(posedge clock) disable iff (rst)
      s_ctrl_read |=> sfr_rdata == $past(voltage_reference_control & arsc_pkg::writable_mask);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_read_idle;
    @(posedge clock) disable iff (rst) !rst && !(sfr_read && hit) |=> sfr_rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without read");

  property p_write_steer;
    @(posedge clock) disable iff (rst)
      s_ctrl_write |-> ##2 steer.thermal_sensor_on == $past(sfr_wdata[arsc_pkg::thermal_sensor_enable_bit], 2);
  endproperty
  a_write_steer: assert property (p_write_steer) else $error("sensor enable not applied");

  property p_write_ref;
    @(posedge clock) disable iff (rst)
      s_ctrl_write |-> ##2 steer.reference_source == $past(sfr_wdata[arsc_pkg::reference_source_select_lsb +: 2], 2);
  endproperty
  a_write_ref: assert property (p_write_ref) else $error("reference select not applied");

  property p_ctrl_hold;
    @(posedge clock) disable iff (rst) !rst && !(sfr_write && hit) |=> $stable(voltage_reference_control);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("register changed without write");
endmodule // arsc_top

// ---- verif/arsc_adc_seq_model.sv ----
// ==========================================
// converter sequencer stand-in
module arsc_adc_seq_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] want,
  input wire logic [4:0] want_ch,
  output logic tracking,
  output logic converting,
  output logic [4:0] channel
);
  timeunit 1ns;
  timeprecision 1ns;
  // code 3 raises both levels; the design must let conversion win
  always_ff @(posedge clock)
  begin
    tracking <= !rst && want[0];
    converting <= !rst && want[1];
    channel <= want_ch;
  end
endmodule // arsc_adc_seq_model

// ---- verif/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, sfr_write = 0, sfr_read = 0, rd_d = 0, st = 0, trk, cnv;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata, r, d;
  logic [1:0] want = 2'h0;
  logic [4:0] want_ch = 5'h00, ch;
  arsc_pkg::arsc_steer_t steer;
  logic [7:0] q[$];
  int errors = 0, n_checks = 0, i, p, k;
  arsc_top DUT(.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
    .sfr_read(sfr_read), .sfr_rdata(rdata), .converter_positive_channel_select(ch),
    .converter_tracking(trk), .converter_converting(cnv), .steer(steer));
  arsc_adc_seq_model seq(.clock(clock), .rst(rst), .want(want), .want_ch(want_ch), .tracking(trk),
    .converting(cnv), .channel(ch));
  initial forever #50 clock = ~clock;
  // ==========================================
  // helpers
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] exp_st(input logic [7:0] v, input int ph, input logic th);
    logic g;
    // overrides beat the ground bit
    g = v[5] && !(ph == 1 && th) && !(ph == 2 && v[4:3] == 2'h3);
    return {2'h0, v[4:3], g, !g, v[4:3] == 2'h3 && ph != 0, v[2]};
  endfunction
  task sfr(input logic w, input logic [7:0] a, input logic [7:0] dat);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= dat;
    sfr_write <= w;
    sfr_read <= !w;
    if (w && a == 8'hD1)
      r = dat & 8'h3C;
    if (!w)
      q.push_back(a == 8'hD1 ? r : 8'h00);
    @(posedge clock);
    sfr_write <= 0;
    sfr_read <= 0;
  endtask
  // inputs held long enough for the three-stage steer path (sequencer, phase, steer registers)
  task look(input int ph, input logic th);
    @(posedge clock);
    want <= ph[1:0];
    want_ch <= th ? 5'h1B : 5'($urandom % 27);
    repeat (4) @(posedge clock);
    q.push_back(exp_st(r, ph == 3 ? 2 : ph, th));
    st <= 1;
    @(posedge clock);
    st <= 0;
  endtask
  // ==========================================
  // monitor
  always @(posedge clock)
  begin
    rd_d <= sfr_read;
    if (rd_d || st)
      check(rd_d ? rdata : {2'h0, steer}, q.pop_front());
  end
  // ==========================================
  // main sequence
  initial
  begin
    k = $urandom(32'h4BF80A05);
    r = 8'h18;
    repeat (3) @(posedge clock);
    rst <= 0;
    sfr(0, 8'hD1, 8'h00);
    look(0, 0);
    for (i = 0; i < 12; i++)
    begin
      k = $urandom;
      // sensor bit by parity so both levels occur
      d = {k[7:6], i[2], i[1:0], ^i[3:0], k[1:0]};
      sfr(1, i == 11 ? 8'hD2 : 8'hD1, d);
      sfr(0, 8'hD1, 8'h00);
      for (p = 0; p < 4; p++)
      begin
        look(p, 0);
        look(p, 1);
      end
    end
    // second reset in mid-run
    @(posedge clock);
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    r = 8'h18;
    sfr(0, 8'hD1, 8'h00);
    look(3, 1);
    sfr(0, 8'hD2, 8'h00);
    for (k = 0; k < 20 && q.size() > 0; k++)
      @(posedge clock);
    if (q.size() > 0)
      errors++;
    end_sim;
  end
endmodule // tb_top
